// ==== alu_unit.v ====
// Arithmetic unit: binary or decimal add and subtract with flags
`timescale 1ns/1ps
`include "core_regs_defines.vh"
module alu_unit (
	// Operands
	input  wire [7:0] op_a,
	input  wire [7:0] op_b,
	input  wire       carry_in,
	input  wire       subtract,
	input  wire       decimal,
	// Results
	output reg  [7:0] result,
	output reg        carry_out,
	output reg        overflow
);
	reg [8:0] bin_sum;    // Binary sum with carry
	reg [7:0] b_eff;      // Operand, inverted for subtract
	reg [4:0] lo;         // Decimal low digit
	reg [4:0] hi;         // Decimal high digit
	reg       lo_c;       // Decimal low digit carry

	// Binary path always forms overflow; decimal corrects digits
	always @* begin
		b_eff = subtract ? ~op_b : op_b;
		bin_sum = {1'b0, op_a} + {1'b0, b_eff} + {8'h00, carry_in};
		overflow = (op_a[7] == b_eff[7]) && (bin_sum[7] != op_a[7]);
		result = bin_sum[7:0];
		carry_out = bin_sum[8];
		lo = 5'h00;
		hi = 5'h00;
		lo_c = 1'b0;
		if (decimal) begin
			// Automatic decimal correction per digit
			if (!subtract) begin
				lo = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]}
					+ {4'h0, carry_in};
				lo_c = (lo > 5'h09);
				if (lo_c)
					lo = lo + 5'h06;
				hi = {1'b0, op_a[7:4]} + {1'b0, op_b[7:4]}
					+ {4'h0, lo_c};
				carry_out = (hi > 5'h09);
				if (carry_out)
					hi = hi + 5'h06;
			end else begin
				lo = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]}
					- {4'h0, ~carry_in};
				lo_c = lo[4];
				if (lo_c)
					lo = lo - 5'h06;
				hi = {1'b0, op_a[7:4]} - {1'b0, op_b[7:4]}
					- {4'h0, lo_c};
				carry_out = ~hi[4];
				if (hi[4])
					hi = hi - 5'h06;
			end
			result = {hi[3:0], lo[3:0]};
		end
	end
endmodule // alu_unit

// ==== core_regs_asserts.sv ====
// Port-level assertions for the core register set and status flags
`timescale 1ns/1ps
`include "core_regs_defines.vh"
module core_regs_asserts (
	// Clock and reset
	input wire        sys_clk,
	input wire        rst_b,
	// Requests
	input wire [4:0]  op_code,
	input wire [7:0]  operand,
	input wire        reg_write,
	input wire [1:0]  branch_flag_sel,
	input wire        mem_write,
	input wire [15:0] mem_addr,
	input wire [7:0]  mem_wdata,
	// Register views
	input wire [7:0]  accumulator,
	input wire [7:0]  index_first,
	input wire [7:0]  index_second,
	input wire [7:0]  stack_pointer,
	input wire [7:0]  processor_status,
	input wire [7:0]  core_mode_register,
	// Derived outputs
	input wire [15:0] stack_address,
	input wire [7:0]  index_first_addr,
	input wire [7:0]  index_second_addr,
	input wire        stack_write,
	input wire [7:0]  stack_wdata,
	input wire        branch_taken,
	input wire        flags_valid,
	input wire        irq_taken,
	input wire        op_refused
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Selector 0..3 maps to status bits 0, 1, 6, 7
	wire sel_flag = processor_status[{branch_flag_sel[1], branch_flag_sel}];
	push_acc_a: assert property (op_code == `OP_PUSH_ACC && !reg_write |=>
		stack_write && stack_wdata == $past(accumulator)
		&& stack_pointer == $past(stack_pointer) - 8'h01) else $error("push bad");
	stack_page_a: assert property (
		stack_address[15:8] == {7'h00, $past(core_mode_register[2])})
		else $error("stack page bad");
	index_sum_a: assert property (
		index_first_addr == $past(operand) + $past(index_first)
		&& index_second_addr == $past(operand) + $past(index_second))
		else $error("index address bad");
	branch_view_a: assert property (branch_taken == $past(sel_flag))
		else $error("branch flag bad");
	decimal_valid_a: assert property (
		flags_valid == !$past(processor_status[3])) else $error("valid bad");
	mode_write_a: assert property (mem_write && mem_addr == `CORE_MODE_ADDR
		|=> core_mode_register == $past(mem_wdata)) else $error("mode bad");
	fast_refused_a: assert property ((op_code == `OP_FAST_A
		|| op_code == `OP_FAST_B) && !reg_write |=> op_refused
		&& $stable(processor_status)) else $error("fast op bad");
	irq_masked_a: assert property (op_code == `OP_INTERRUPT
		&& processor_status[2] && !reg_write |=> !irq_taken)
		else $error("masked irq taken");
	// Main scenarios
	cover property (op_code == `OP_BREAK ##1 irq_taken);
	cover property (op_refused);
	cover property (stack_address[8]);
endmodule // core_regs_asserts

// ==== core_regs_defines.vh ====
// Constants for the core register set and status flag block
`ifndef CORE_REGS_DEFINES_VH
`define CORE_REGS_DEFINES_VH

// Status flag bit positions
`define FLAG_CARRY        0
`define FLAG_ZERO         1
`define FLAG_IRQ_MASK     2
`define FLAG_DECIMAL      3
`define FLAG_BREAK        4
`define FLAG_INDEX_MODE   5
`define FLAG_OVERFLOW     6
`define FLAG_NEGATIVE     7

// Reset values
`define RESET_STATUS      8'h04
`define RESET_DATA        8'h00
`define RESET_COUNTER     16'h0000
`define RESET_STACK       8'hFF
`define RESET_MODE        8'h00

// Core mode register address and its stack page bit
`define CORE_MODE_ADDR    16'h003B
`define MODE_STACK_PAGE   2

// Stack page high bytes
`define STACK_PAGE_ZERO   8'h00
`define STACK_PAGE_ONE    8'h01

// Flag operation codes (op_code input)
`define OP_NONE           5'h00
`define OP_RAISE_CARRY    5'h01
`define OP_DROP_CARRY     5'h02
`define OP_RAISE_IRQ      5'h03
`define OP_DROP_IRQ       5'h04
`define OP_RAISE_DECIMAL  5'h05
`define OP_DROP_DECIMAL   5'h06
`define OP_RAISE_INDEX    5'h07
`define OP_DROP_INDEX     5'h08
`define OP_DROP_OVERFLOW  5'h09
`define OP_PUSH_ACC       5'h0A
`define OP_POP_ACC        5'h0B
`define OP_PUSH_STATUS    5'h0C
`define OP_POP_STATUS     5'h0D
`define OP_BIT_TEST       5'h0E
`define OP_ARITH          5'h0F
`define OP_TRANSFER       5'h10
`define OP_SHIFT          5'h11
`define OP_FAST_A         5'h12
`define OP_FAST_B         5'h13
`define OP_STOP           5'h14
`define OP_WAIT           5'h15
`define OP_INTERRUPT      5'h16
`define OP_BREAK          5'h17
`define OP_PRODUCT        5'h18
`define OP_DIVIDE         5'h19

// Register select codes for writes
`define SEL_ACC           3'h0
`define SEL_INDEX_FIRST   3'h1
`define SEL_INDEX_SECOND  3'h2
`define SEL_STACK         3'h3
`define SEL_COUNTER       3'h4
`define SEL_STATUS        3'h5

`endif

// ==== cpu_core_registers_flags.v ====
// Programmer-visible register set and status flags of the core
// Contract
// - Eight-bit accumulator is main operand and destination
// - First index adds to operand for address
// - Second index adds to operand for address
// - Stack high byte from page select bit
// - Sixteen-bit counter from high and low bytes
// - Eight-bit status; branches test C Z V N
// - Z, V, N invalid in decimal mode
// - Bit 0 holds carry; shifts update it
// - Bit 1 set on zero result
// - Bit 2 blocks all but break interrupts
// - Bit 3 selects decimal add/subtract only
// - Bit 4 set by break, cleared otherwise
// - Bit 5 selects memory-to-memory operation
// - Bit 6 signed overflow; bit test copies
// - Bit 7 negative; bit test copies bit 7
// - Set/clear ops for C,I,D,T; clear V
// - Push and pop accumulator and status
// - Fast ops refused; stop, wait, multiply, divide
// - Page bit lives in mode register 003B
`timescale 1ns/1ps
`include "core_regs_defines.vh"
module cpu_core_registers_flags (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst_b,
	// Operation request
	input  wire [4:0]  op_code,
	input  wire [7:0]  operand,
	input  wire        alu_subtract,
	input  wire [7:0]  shift_result,
	input  wire        shift_carry,
	// Direct register write
	input  wire        reg_write,
	input  wire [2:0]  reg_select,
	input  wire [15:0] reg_wdata,
	// Branch test
	input  wire [1:0]  branch_flag_sel,
	// Memory-side write of the core mode register
	input  wire        mem_write,
	input  wire [15:0] mem_addr,
	input  wire [7:0]  mem_wdata,
	// Interrupt request
	input  wire        irq_request,
	// Counter control
	input  wire        counter_step,
	input  wire        counter_load,
	input  wire [15:0] counter_target,
	// Register views
	output reg  [7:0]  accumulator,
	output reg  [7:0]  index_first,
	output reg  [7:0]  index_second,
	output reg  [7:0]  stack_pointer,
	output reg  [7:0]  counter_high_byte,
	output reg  [7:0]  counter_low_byte,
	output reg  [7:0]  processor_status,
	output reg  [7:0]  core_mode_register,
	// Addresses
	output reg  [15:0] stack_address,
	output reg  [7:0]  index_first_addr,
	output reg  [7:0]  index_second_addr,
	// Stack bus
	output reg         stack_write,
	output reg  [7:0]  stack_wdata,
	// Status outputs
	output reg         branch_taken,
	output reg         flags_valid,
	output reg         mem_to_mem,
	output reg         irq_taken,
	output reg         op_refused,
	output reg         core_halted,
	output reg         core_waiting
);
	wire [7:0]  alu_result;    // Adder result
	wire        alu_carry;     // Adder carry out
	wire        alu_overflow;  // Adder signed overflow
	wire [7:0]  next_flags;    // Flags after this op
	reg  [7:0]  flag_result;   // Result shown to the flag unit
	reg         flag_carry;    // Carry shown to the flag unit
	reg  [7:0]  flag_src;      // Status after interrupt handling
	reg  [4:0]  flag_op;       // Op shown to the flag unit
	reg  [7:0]  next_stack;    // Stack pointer after this op
	reg  [7:0]  stack_low;     // Stack byte address low part
	reg  [7:0]  pushed_status; // Status image written on interrupt
	reg         irq_ok;        // Interrupt request is accepted
	reg         is_break;      // Break interrupt request
	reg         branch_bit;    // Flag chosen for a branch
	reg  [15:0] counter;       // Full program counter
	reg  [7:0]  product_hi;    // Upper product byte
	reg  [15:0] product;       // Multiply product
	// Reset image of the program counter, split into bytes below
	localparam [15:0] RESET_PC = `RESET_COUNTER;

	// Shared adder on the accumulator
	alu_unit u_alu (
		.op_a      (accumulator),
		.op_b      (operand),
		.carry_in  (processor_status[`FLAG_CARRY]),
		.subtract  (alu_subtract),
		.decimal   (processor_status[`FLAG_DECIMAL]),
		.result    (alu_result),
		.carry_out (alu_carry),
		.overflow  (alu_overflow)
	);

	// Flag update logic
	flag_unit u_flags (
		.status      (flag_src),
		.op_code     (flag_op),
		.result      (flag_result),
		.carry_out   (flag_carry),
		.overflow    (alu_overflow),
		.operand     (operand),
		.pop_data    (operand),
		.next_status (next_flags)
	);

	// Interrupt acceptance, break flag image and flag unit inputs
	always @* begin
		// Break is its own interrupt source, never masked
		is_break = (op_code == `OP_BREAK);
		// Masked unless the break op raised it
		irq_ok = is_break ||
			(op_code == `OP_INTERRUPT && irq_request &&
			!processor_status[`FLAG_IRQ_MASK]);
		// Stacked image: break bit tells the handler who called
		pushed_status = processor_status;
		pushed_status[`FLAG_BREAK] = is_break;
		// An accepted interrupt masks further ones at once
		flag_src = processor_status;
		if (irq_ok)
			flag_src[`FLAG_IRQ_MASK] = 1'b1;
		// Defaults: the op itself, fed by the adder
		flag_op = op_code;
		flag_result = alu_result;
		flag_carry = alu_carry;
		// Other result sources per op
		case (op_code)
		// External shifter supplies result and carry
		`OP_SHIFT: begin
			flag_result = shift_result;
			flag_carry = shift_carry;
		end
		// Moved byte sets zero and negative
		`OP_TRANSFER, `OP_POP_ACC: flag_result = operand;
		// Zero from the masked accumulator
		`OP_BIT_TEST: flag_result = accumulator & operand;
		// Arithmetic and all others use the adder
		default: flag_result = alu_result;
		endcase
	end

	// Stack pointer movement and stack address low byte
	always @* begin
		next_stack = stack_pointer;
		// Push writes at the current pointer
		stack_low = stack_pointer;
		case (op_code)
		// Push moves down one byte
		`OP_PUSH_ACC, `OP_PUSH_STATUS:
			next_stack = stack_pointer - 8'h01;
		// Pop moves up one and reads the byte it lands on
		`OP_POP_ACC, `OP_POP_STATUS: begin
			next_stack = stack_pointer + 8'h01;
			stack_low = next_stack;
		end
		// Interrupt frame: counter bytes and status
		`OP_INTERRUPT, `OP_BREAK:
			if (irq_ok)
				next_stack = stack_pointer - 8'h03;
		// Other ops leave the stack alone
		default: next_stack = stack_pointer;
		endcase
	end

	// Branch condition select: C, Z, V, N
	always @* begin
		// Flag order of the selector: C, Z, V, N
		case (branch_flag_sel)
		2'h0: branch_bit = processor_status[`FLAG_CARRY];
		2'h1: branch_bit = processor_status[`FLAG_ZERO];
		2'h2: branch_bit = processor_status[`FLAG_OVERFLOW];
		// Selector 3: negative flag
		default: branch_bit = processor_status[`FLAG_NEGATIVE];
		endcase
		// Whole counter, seen as one word for stepping
		counter = {counter_high_byte, counter_low_byte};
		// Both operands widened so the top byte is kept
		product = {8'h00, accumulator} * {8'h00, operand};
		// Upper byte goes to the first index
		product_hi = product[15:8];
	end

	// Main register state
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			// Data registers clear; stack starts at the page top
			accumulator <= `RESET_DATA;
			index_first <= `RESET_DATA;
			index_second <= `RESET_DATA;
			stack_pointer <= `RESET_STACK;
			// Counter bytes from the reset address image
			counter_high_byte <= RESET_PC[15:8];
			counter_low_byte <= RESET_PC[7:0];
			processor_status <= `RESET_STATUS;
			core_mode_register <= `RESET_MODE;
			// Stack bus idle
			stack_write <= 1'b0;
			stack_wdata <= `RESET_DATA;
			// Pulses and sticky levels low
			irq_taken <= 1'b0;
			op_refused <= 1'b0;
			core_halted <= 1'b0;
			core_waiting <= 1'b0;
		end else begin
			// Pulses last a single cycle unless set again below
			stack_write <= 1'b0;
			irq_taken <= 1'b0;
			op_refused <= 1'b0;
			// Eight register bytes held in flops
			// Status follows the flag unit every cycle without a status load
			processor_status <= next_flags;
			// Stack pointer follows pushes, pops and interrupts
			stack_pointer <= next_stack;
			// Counter advance or jump
			if (counter_load)
				// A jump wins over a step in the same cycle
				{counter_high_byte, counter_low_byte} <=
					counter_target;
			else if (counter_step)
				// Carry from the low byte ripples into the high
				{counter_high_byte, counter_low_byte} <=
					counter + 16'h0001;
			// Op effects on data registers
			case (op_code)
			// Adder result returns to the accumulator
			`OP_ARITH: accumulator <= alu_result;
			// Shifted byte from the external shifter
			`OP_SHIFT: accumulator <= shift_result;
			// Popped byte arrives on the operand bus
			`OP_POP_ACC: accumulator <= operand;
			// Accumulator goes out on the stack bus
			`OP_PUSH_ACC: begin
				stack_write <= 1'b1;
				stack_wdata <= accumulator;
			end
			// Status goes out as it stands, break bit included
			`OP_PUSH_STATUS: begin
				stack_write <= 1'b1;
				stack_wdata <= processor_status;
			end
			// Accepted interrupt stacks the status image
			`OP_INTERRUPT, `OP_BREAK: begin
				if (irq_ok) begin
					stack_write <= 1'b1;
					stack_wdata <= pushed_status;
					irq_taken <= 1'b1;
				end
				// Any interrupt op ends a wait
				core_waiting <= 1'b0;
			end
			// Fast-mode ops are not available: flag, no effect
			`OP_FAST_A, `OP_FAST_B: op_refused <= 1'b1;
			// Stop holds until the next reset
			`OP_STOP: core_halted <= 1'b1;
			// Wait holds until an interrupt op
			`OP_WAIT: core_waiting <= 1'b1;
			// Product of accumulator and operand byte
			`OP_PRODUCT: begin
				// Product high byte to first index, low to acc
				accumulator <= product[7:0];
				index_first <= product_hi;
			end
			// Divide the accumulator by the operand byte
			`OP_DIVIDE: begin
				// Quotient to acc; divide by zero leaves state
				if (operand != 8'h00)
					accumulator <= accumulator / operand;
				// Remainder to the first index, same guard
				index_first <= (operand != 8'h00) ?
					accumulator % operand : index_first;
			end
			// Flag ops and idle touch no data register
			default: op_refused <= 1'b0;
			endcase
			// Direct register loads; written last so they win
			if (reg_write) begin
				case (reg_select)
				// Byte registers take the low half of the word
				`SEL_ACC: accumulator <= reg_wdata[7:0];
				`SEL_INDEX_FIRST: index_first <= reg_wdata[7:0];
				`SEL_INDEX_SECOND: index_second <= reg_wdata[7:0];
				`SEL_STACK: stack_pointer <= reg_wdata[7:0];
				// Counter takes the whole word, high byte first
				`SEL_COUNTER:
					{counter_high_byte, counter_low_byte} <=
						reg_wdata;
				// Status load overrides the flag unit
				`SEL_STATUS: processor_status <= reg_wdata[7:0];
				// Unused select codes load nothing
				default: accumulator <= accumulator;
				endcase
			end
			// Core mode register at its memory address
			// Other addresses belong to other blocks
			if (mem_write && mem_addr == `CORE_MODE_ADDR)
				// Only its stack page bit is used here
				core_mode_register <= mem_wdata;
		end
	end

	// Registered address and status views
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			// Stack page 00 with the reset stack pointer
			stack_address <= {`STACK_PAGE_ZERO, `RESET_STACK};
			// Address views start from zero
			index_first_addr <= `RESET_DATA;
			index_second_addr <= `RESET_DATA;
			branch_taken <= 1'b0;
			// Binary mode after reset, so flags are valid
			flags_valid <= 1'b1;
			mem_to_mem <= 1'b0;
		end else begin
			// Page select picks stack page 00 or 01
			stack_address <= {core_mode_register[`MODE_STACK_PAGE] ?
				`STACK_PAGE_ONE : `STACK_PAGE_ZERO,
				stack_low};
			// Indexed addresses wrap within the byte
			index_first_addr <= operand + index_first;
			index_second_addr <= operand + index_second;
			// Branch test of the chosen flag
			branch_taken <= branch_bit;
			// Zero, overflow and negative untrusted in decimal
			flags_valid <= !processor_status[`FLAG_DECIMAL];
			// Memory-to-memory mode follows the index mode flag
			mem_to_mem <= processor_status[`FLAG_INDEX_MODE];
		end
	end
endmodule // cpu_core_registers_flags

// ==== cpu_core_registers_flags_tb.sv ====
// Self-checking bench for the core register set and flags
`timescale 1ns/1ps
`include "core_regs_defines.vh"
module cpu_core_registers_flags_tb;
	// Stimulus
	reg        sys_clk, rst_b, alu_subtract, shift_carry, reg_write;
	reg        mem_write, irq_request, counter_step, counter_load;
	reg [4:0]  op_code;
	reg [7:0]  operand, shift_result, mem_wdata;
	reg [2:0]  reg_select;
	reg [1:0]  branch_flag_sel;
	reg [15:0] reg_wdata, mem_addr, counter_target;
	// Observed outputs
	wire [7:0]  accumulator, index_first, index_second, stack_pointer;
	wire [7:0]  counter_high_byte, counter_low_byte, processor_status;
	wire [7:0]  core_mode_register, index_first_addr, index_second_addr;
	wire [7:0]  stack_wdata;
	wire [15:0] stack_address;
	wire        stack_write, branch_taken, flags_valid, mem_to_mem;
	wire        irq_taken, op_refused, core_halted, core_waiting;
	// Pulse snapshots and counters
	reg         s_wr, s_irq, s_ref;
	reg [7:0]   s_wd;
	integer     fail_count, n_compared, cycles;

	cpu_core_registers_flags u_dut (.sys_clk, .rst_b, .op_code, .operand,
		.alu_subtract, .shift_result, .shift_carry, .reg_write,
		.reg_select, .reg_wdata, .branch_flag_sel, .mem_write, .mem_addr,
		.mem_wdata, .irq_request, .counter_step, .counter_load,
		.counter_target, .accumulator, .index_first, .index_second,
		.stack_pointer, .counter_high_byte, .counter_low_byte,
		.processor_status, .core_mode_register, .stack_address,
		.index_first_addr, .index_second_addr, .stack_write, .stack_wdata,
		.branch_taken, .flags_valid, .mem_to_mem, .irq_taken, .op_refused,
		.core_halted, .core_waiting);

	// 10 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// Hang guard
	always @(posedge sys_clk) begin
		cycles = cycles + 1;
		if (cycles == 2000) begin
			fail_count = fail_count + 1;
			conclude;
		end
	end
	// Compare and count
	task chk(input [63:0] nm, input [15:0] seen, input [15:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("[FAIL] %0s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask
	// One op; pulses captured after one edge, then a second edge so views settle
	task op(input [4:0] c, input [7:0] d);
		begin
			op_code = c;
			operand = d;
			@(negedge sys_clk);
			s_wr = stack_write;
			s_wd = stack_wdata;
			s_irq = irq_taken;
			s_ref = op_refused;
			op_code = `OP_NONE;
			@(negedge sys_clk);
		end
	endtask
	// Direct register load
	task wr(input [2:0] s, input [15:0] d);
		begin
			reg_write = 1'b1;
			reg_select = s;
			reg_wdata = d;
			@(negedge sys_clk);
			reg_write = 1'b0;
			@(negedge sys_clk);
		end
	endtask
	// Memory-side write
	task mw(input [15:0] a, input [7:0] d);
		begin
			mem_write = 1'b1;
			mem_addr = a;
			mem_wdata = d;
			@(negedge sys_clk);
			mem_write = 1'b0;
			@(negedge sys_clk);
		end
	endtask
	// Flag op and its bit
	task fl(input [4:0] c, input [2:0] b, input v);
		begin
			op(c, 8'h00);
			chk("flag", processor_status[b], v);
		end
	endtask
	// Reset values
	task t_reset;
		begin
			chk("sp", stack_pointer, 8'hFF);
			chk("ps", processor_status, 8'h04);
			chk("saddr", stack_address, 16'h00FF);
			chk("acc", accumulator, 8'h00);
			chk("pc", {counter_high_byte, counter_low_byte}, 16'h0000);
			chk("halt", {core_halted, core_waiting}, 2'b00);
		end
	endtask
	// Adder flags, decimal mode, bit test, shift
	task t_arith;
		begin
			wr(`SEL_ACC, 16'h0050);
			fl(`OP_DROP_CARRY, 0, 1'b0);
			op(`OP_ARITH, 8'h50);
			chk("acc", accumulator, 8'hA0);
			chk("nvzc", processor_status & 8'hC3, 8'hC0);
			fl(`OP_DROP_OVERFLOW, 6, 1'b0);
			fl(`OP_RAISE_CARRY, 0, 1'b1);
			alu_subtract = 1'b1;
			op(`OP_ARITH, 8'hA0);
			alu_subtract = 1'b0;
			chk("nvzc", processor_status & 8'hC3, 8'h03);
			fl(`OP_RAISE_DECIMAL, 3, 1'b1);
			fl(`OP_DROP_CARRY, 0, 1'b0);
			wr(`SEL_ACC, 16'h0009);
			op(`OP_ARITH, 8'h01);
			chk("bcd", accumulator, 8'h10);
			chk("fvalid", flags_valid, 1'b0);
			fl(`OP_DROP_DECIMAL, 3, 1'b0);
			chk("fvalid", flags_valid, 1'b1);
			op(`OP_BIT_TEST, 8'hC0);
			chk("nv", processor_status[7:6], 2'b11);
			op(`OP_BIT_TEST, 8'h3F);
			chk("nv", processor_status[7:6], 2'b00);
			op(`OP_TRANSFER, 8'h80);
			chk("nz", {processor_status[7], processor_status[1]}, 2'b10);
			op(`OP_TRANSFER, 8'h00);
			chk("nz", {processor_status[7], processor_status[1]}, 2'b01);
			shift_carry = 1'b1;
			op(`OP_SHIFT, 8'h00);
			chk("c", processor_status[0], 1'b1);
			shift_carry = 1'b0;
			op(`OP_SHIFT, 8'h00);
			chk("c", processor_status[0], 1'b0);
			fl(`OP_RAISE_INDEX, 5, 1'b1);
			chk("m2m", mem_to_mem, 1'b1);
			fl(`OP_DROP_INDEX, 5, 1'b0);
		end
	endtask
	// Push, pop and stack page
	task t_stack;
		begin
			wr(`SEL_ACC, 16'h005A);
			op(`OP_PUSH_ACC, 8'h00);
			chk("push", {s_wr, s_wd}, 9'h15A);
			chk("saddr", stack_address, 16'h00FE);
			op(`OP_POP_ACC, 8'h3C);
			chk("pop", {accumulator, stack_pointer}, 16'h3CFF);
			op(`OP_POP_STATUS, 8'hC3);
			chk("ps", processor_status, 8'hC3);
			op(`OP_PUSH_STATUS, 8'h00);
			chk("pushps", {s_wr, s_wd & 8'hCF}, 9'h1C3);
			mw(16'h003B, 8'h04);
			chk("saddr", stack_address, 16'h01FF);
			mw(16'h003C, 8'h00);
			chk("mode", core_mode_register, 8'h04);
			mw(16'h003B, 8'h00);
			chk("saddr", stack_address, 16'h00FF);
		end
	endtask
	// Masked interrupt, break, taken interrupt
	task t_irq;
		begin
			fl(`OP_RAISE_IRQ, 2, 1'b1);
			irq_request = 1'b1;
			op(`OP_INTERRUPT, 8'h00);
			chk("irq", s_irq, 1'b0);
			op(`OP_BREAK, 8'h00);
			chk("brk", {s_irq, s_wd[4], stack_pointer}, 10'h3FC);
			fl(`OP_DROP_IRQ, 2, 1'b0);
			op(`OP_INTERRUPT, 8'h00);
			chk("irq", {s_irq, s_wd[4], stack_pointer}, 10'h2F9);
			chk("imask", processor_status[2], 1'b1);
			op(`OP_PUSH_ACC, 8'h00);
			chk("save", {s_wr, s_wd}, 9'h13C);
			irq_request = 1'b0;
		end
	endtask
	// Index sums, counter, branch selector, product and refusals
	task t_misc;
		integer i;
		reg [7:0] ps;
		begin
			wr(`SEL_INDEX_FIRST, 16'h00F0);
			wr(`SEL_INDEX_SECOND, 16'h007F);
			operand = 8'h20;
			@(negedge sys_clk);
			chk("ixa", {index_first_addr, index_second_addr}, 16'h109F);
			counter_target = 16'h12FF;
			counter_load = 1'b1;
			@(negedge sys_clk);
			counter_load = 1'b0;
			counter_step = 1'b1;
			chk("pc", {counter_high_byte, counter_low_byte}, 16'h12FF);
			@(negedge sys_clk);
			counter_step = 1'b0;
			chk("pc", {counter_high_byte, counter_low_byte}, 16'h1300);
			wr(`SEL_STATUS, 16'h0041);
			for (i = 0; i < 4; i = i + 1) begin
				branch_flag_sel = i[1:0];
				@(negedge sys_clk);
				@(negedge sys_clk);
				chk("branch", branch_taken, i % 2 == 0);
			end
			wr(`SEL_ACC, 16'h0012);
			wr(`SEL_INDEX_FIRST, 16'h0010);
			op(`OP_PRODUCT, 8'h10);
			chk("prod", {index_first, accumulator}, 16'h0120);
			ps = processor_status;
			op(`OP_FAST_A, 8'h00);
			chk("fast", {s_ref, processor_status}, {1'b1, ps});
			op(`OP_FAST_B, 8'h00);
			chk("fast", {s_ref, accumulator}, 9'h120);
			op(`OP_DIVIDE, 8'h06);
			chk("div", {index_first, accumulator}, 16'h0205);
			op(`OP_DIVIDE, 8'h00);
			chk("div0", {index_first, accumulator}, 16'h0205);
			op(`OP_WAIT, 8'h00);
			chk("wait", core_waiting, 1'b1);
			op(`OP_STOP, 8'h00);
			chk("stop", core_halted, 1'b1);
		end
	endtask
	// Verdict
	task conclude;
		begin
			$display("compared %0d failed %0d", n_compared, fail_count);
			if (fail_count == 0 && n_compared > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	// Main sequence, with a second reset out of the stopped state
	initial begin
		{rst_b, alu_subtract, shift_carry, reg_write, mem_write} = 5'h00;
		{irq_request, counter_step, counter_load, branch_flag_sel} = 5'h00;
		{op_code, operand, shift_result, mem_wdata} = 29'h00000000;
		{reg_select, reg_wdata, mem_addr, counter_target} = 51'h0;
		{fail_count, n_compared, cycles} = 96'h0;
		shift_result = 8'h81;
		repeat (8) @(negedge sys_clk);
		rst_b = 1'b1;
		t_reset;
		t_arith;
		t_stack;
		t_irq;
		t_misc;
		rst_b = 1'b0;
		repeat (8) @(negedge sys_clk);
		rst_b = 1'b1;
		t_reset;
		conclude;
	end
endmodule // cpu_core_registers_flags_tb

bind cpu_core_registers_flags core_regs_asserts u_chk (.sys_clk, .rst_b,
	.op_code, .operand, .reg_write, .branch_flag_sel, .mem_write, .mem_addr,
	.mem_wdata, .accumulator, .index_first, .index_second, .stack_pointer,
	.processor_status, .core_mode_register, .stack_address,
	.index_first_addr, .index_second_addr, .stack_write, .stack_wdata,
	.branch_taken, .flags_valid, .irq_taken, .op_refused);

// ==== flag_unit.v ====
// Next processor status from the current op and unit results
`timescale 1ns/1ps
`include "core_regs_defines.vh"
module flag_unit (
	// Current state and op
	input  wire [7:0] status,
	input  wire [4:0] op_code,
	input  wire [7:0] result,
	input  wire       carry_out,
	input  wire       overflow,
	input  wire [7:0] operand,
	input  wire [7:0] pop_data,
	// New status
	output reg  [7:0] next_status
);
	// Apply set/clear, result and test updates
	always @* begin
		next_status = status;
		case (op_code)
		`OP_RAISE_CARRY:   next_status[`FLAG_CARRY] = 1'b1;
		`OP_DROP_CARRY:    next_status[`FLAG_CARRY] = 1'b0;
		`OP_RAISE_IRQ:     next_status[`FLAG_IRQ_MASK] = 1'b1;
		`OP_DROP_IRQ:      next_status[`FLAG_IRQ_MASK] = 1'b0;
		`OP_RAISE_DECIMAL: next_status[`FLAG_DECIMAL] = 1'b1;
		`OP_DROP_DECIMAL:  next_status[`FLAG_DECIMAL] = 1'b0;
		`OP_RAISE_INDEX:   next_status[`FLAG_INDEX_MODE] = 1'b1;
		`OP_DROP_INDEX:    next_status[`FLAG_INDEX_MODE] = 1'b0;
		`OP_DROP_OVERFLOW: next_status[`FLAG_OVERFLOW] = 1'b0;
		`OP_POP_STATUS:    next_status = pop_data;
		`OP_ARITH: begin
			// Carry, zero, overflow, negative from the adder
			next_status[`FLAG_CARRY] = carry_out;
			next_status[`FLAG_ZERO] = (result == 8'h00);
			next_status[`FLAG_OVERFLOW] = overflow;
			next_status[`FLAG_NEGATIVE] = result[7];
		end
		`OP_SHIFT: begin
			// Shifts move carry and set result flags
			next_status[`FLAG_CARRY] = carry_out;
			next_status[`FLAG_ZERO] = (result == 8'h00);
			next_status[`FLAG_NEGATIVE] = result[7];
		end
		`OP_TRANSFER, `OP_POP_ACC: begin
			// Data transfer result flags
			next_status[`FLAG_ZERO] = (result == 8'h00);
			next_status[`FLAG_NEGATIVE] = result[7];
		end
		`OP_BIT_TEST: begin
			// Copy operand bits 6 and 7, zero from and with acc
			next_status[`FLAG_OVERFLOW] = operand[6];
			next_status[`FLAG_NEGATIVE] = operand[7];
			next_status[`FLAG_ZERO] = (result == 8'h00);
		end
		default: next_status = status;
		endcase
	end
endmodule // flag_unit
